// file: src/sicm_pkg.sv
package sicm_pkg;

   // ---------------------------------------------------------------
   // channel and image layout
   // ---------------------------------------------------------------
   localparam int          SICM_NUM_CHAN      = 16;
   localparam int          SICM_SYNC_STAGES   = 2;
   localparam logic [7:0]  SICM_IMG_BYTE0_OFS = 8'h00;
   localparam logic [7:0]  SICM_IMG_BYTE1_OFS = 8'h01;
   localparam int          SICM_OUT_AREA_LEN  = 0;
   localparam logic [15:0] SICM_IMG_RST       = 16'h0000;
   localparam logic [7:0]  SICM_RD_UNMAPPED   = 8'h00;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int SICM_CLK_HZ        = 100_000_000;
   localparam int SICM_BLINK_HZ      = 1;
   localparam int SICM_BLINK_HALF_CYC = SICM_CLK_HZ / (2 * SICM_BLINK_HZ);

   // module id, value is arbitrary
   localparam logic [31:0] SICM_MODULE_ID = 32'h0000_0a5a;

   // ---------------------------------------------------------------
   // status bar indicator modes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SICM_LED_OFF    = 3'b001,
      SICM_LED_STEADY = 3'b010,
      SICM_LED_BLINK  = 3'b100
   } sicm_led_mode_t;

endpackage : sicm_pkg

// file: src/sicm_sync.sv
`timescale 1ns/10ps
module sicm_sync
   import sicm_pkg::*;
#(
   parameter int WIDTH  = SICM_NUM_CHAN,
   parameter int STAGES = SICM_SYNC_STAGES
) (
   // clock and control
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             ce,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ---------------------------------------------------------------
   // per bit shift chain
   // ---------------------------------------------------------------
   // first stage feeds only the second, never any logic
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic [STAGES-1:0] chain_ff;
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               chain_ff <= '0;
            end else if (ce) begin
               chain_ff <= {chain_ff[STAGES-2:0], async_in[gi]}; // R11
            end
         end
         assign sync_out[gi] = chain_ff[STAGES-1];
      end
   endgenerate

endmodule : sicm_sync

// file: src/sicm_top.sv
// Notes on behaviour
// (R1) sixteen independent input channels reported to the controller
// (R2) channels 0-7 in image byte 0, 8-15 in byte 1, bit per channel
// (R3) image sits at base offset zero of the controller input area
// (R4) no output area bytes; controller output data is never accepted
// (R5) green status bar steady when backplane ok and module healthy
// (R6) red status bar steady while module reports an error; code blinks it instead when config_error is also set
// (R7) red status bar blinks at 1 Hz on configuration error
// (R8) green status bar blinks at 1 Hz on backplane failure
// (R9) channel green indicator lit while channel is at one
// (R10) channel green indicator dark while channel is at zero
// (R11) every channel passes two flip-flops before image or indicator
`timescale 1ns/10ps
module sicm_top
   import sicm_pkg::*;
#(
   parameter int NUM_CHAN       = SICM_NUM_CHAN,
   parameter int BLINK_HALF_CYC = SICM_BLINK_HALF_CYC
) (
   // clock and control
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire logic                ce,
   // field inputs, asynchronous
   input  wire logic [NUM_CHAN-1:0] binary_input_channel,
   // module health, from logic on clk_sys
   input  wire logic                bus_comm_ok,
   input  wire logic                module_error,
   input  wire logic                config_error,
   // input area read port
   input  wire logic                img_rd_en,
   input  wire logic [7:0]          img_rd_addr,
   output logic                     img_rd_valid_ff,
   output logic [7:0]               img_rd_data_ff,
   output logic                     img_rd_unmapped_ff,
   // parallel image
   output logic [NUM_CHAN-1:0]      input_process_image_ff,
   // indicators
   output logic [NUM_CHAN-1:0]      chan_led_green_ff,
   output logic                     bar_led_green_ff,
   output logic                     bar_led_red_ff
);

   // counter sized for the half period, 0.5 s by default
   localparam int CNT_W = $clog2(BLINK_HALF_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BLINK_HALF_CYC - 1);

   // ---------------------------------------------------------------
   // input synchronisation
   // ---------------------------------------------------------------
   // pins move at any time against clk_sys, hence two stages
   logic [NUM_CHAN-1:0] chan_sync;

   sicm_sync #(
      .WIDTH  (NUM_CHAN),
      .STAGES (SICM_SYNC_STAGES)
   ) u_sync (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .ce       (ce),
      .async_in (binary_input_channel),
      .sync_out (chan_sync)
   );

   // ---------------------------------------------------------------
   // input image and channel indicators
   // ---------------------------------------------------------------
   // image and indicators share the same synchronised sample
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         input_process_image_ff <= NUM_CHAN'(SICM_IMG_RST);
      end else if (ce) begin
         input_process_image_ff <= chan_sync; // R1 R2
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         chan_led_green_ff <= '0;
      end else if (ce) begin
         chan_led_green_ff <= chan_sync; // R9 R10
      end
   end

   // ---------------------------------------------------------------
   // input area read port
   // ---------------------------------------------------------------
   // only reads exist: the module owns no output area bytes (R4)
   // bytes are read apart, no snapshot: a change between reads can tear
   logic [15:0] img_word;
   logic [7:0]  nxt_rd_data;
   logic        nxt_rd_unmapped;

   assign img_word = 16'(input_process_image_ff);

   always_comb begin
      nxt_rd_data     = SICM_RD_UNMAPPED;
      nxt_rd_unmapped = 1'b0;
      case (img_rd_addr)
         SICM_IMG_BYTE0_OFS: nxt_rd_data = img_word[7:0];  // R2 R3
         SICM_IMG_BYTE1_OFS: nxt_rd_data = img_word[15:8]; // R2 R3
         default:            nxt_rd_unmapped = 1'b1; // R4
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         img_rd_valid_ff <= 1'b0;
      end else if (ce) begin
         img_rd_valid_ff <= img_rd_en; // R3
      end
   end

   // data and flag hold until the next read is taken
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         img_rd_data_ff <= 8'h00;
      end else if (ce && img_rd_en) begin
         img_rd_data_ff <= nxt_rd_data; // R2 R3
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         img_rd_unmapped_ff <= 1'b0;
      end else if (ce && img_rd_en) begin
         img_rd_unmapped_ff <= nxt_rd_unmapped; // R4
      end
   end

   // ---------------------------------------------------------------
   // 1 hz blink base
   // ---------------------------------------------------------------
   // one shared base keeps red and green blinking in step
   logic [CNT_W-1:0] blink_cnt_ff;
   logic             blink_phase_ff;
   logic             blink_wrap;

   assign blink_wrap = (blink_cnt_ff == CNT_LAST);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blink_cnt_ff <= '0;
      end else if (ce) begin
         if (blink_wrap) begin
            blink_cnt_ff <= '0;
         end else begin
            blink_cnt_ff <= blink_cnt_ff + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blink_phase_ff <= 1'b0;
      end else if (ce && blink_wrap) begin
         blink_phase_ff <= ~blink_phase_ff; // R7 R8
      end
   end

   // ---------------------------------------------------------------
   // status bar mode selection
   // ---------------------------------------------------------------
   // config error outranks plain module error on the red bar
   // any fault darkens green steady, only a bus failure blinks it
   sicm_led_mode_t red_mode;
   sicm_led_mode_t green_mode;

   always_comb begin
      if (config_error) begin
         red_mode = SICM_LED_BLINK; // R7
      end else if (module_error) begin
         red_mode = SICM_LED_STEADY; // R6
      end else begin
         red_mode = SICM_LED_OFF;
      end
   end

   always_comb begin
      if (!bus_comm_ok) begin
         green_mode = SICM_LED_BLINK; // R8
      end else if (!module_error && !config_error) begin
         green_mode = SICM_LED_STEADY; // R5
      end else begin
         green_mode = SICM_LED_OFF;
      end
   end

   function automatic logic led_level(input sicm_led_mode_t mode,
                                      input logic phase);
      case (mode)
         SICM_LED_OFF:    led_level = 1'b0;
         SICM_LED_STEADY: led_level = 1'b1;
         SICM_LED_BLINK:  led_level = phase;
         default:         led_level = 1'b0;
      endcase
   endfunction : led_level

   // ---------------------------------------------------------------
   // status bar drivers
   // ---------------------------------------------------------------
   logic nxt_bar_red;
   logic nxt_bar_green;

   assign nxt_bar_red   = led_level(red_mode, blink_phase_ff);
   assign nxt_bar_green = led_level(green_mode, blink_phase_ff);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bar_led_red_ff <= 1'b0;
      end else if (ce) begin
         bar_led_red_ff <= nxt_bar_red; // R6 R7
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bar_led_green_ff <= 1'b0;
      end else if (ce) begin
         bar_led_green_ff <= nxt_bar_green; // R5 R8
      end
   end

endmodule : sicm_top

// file: verif/sicm_chk.sv
`timescale 1ns/10ps
module sicm_chk #(
   parameter int NUM_CHAN       = 16,
   parameter int BLINK_HALF_CYC = 50_000_000
) (
   // clock and control
   input wire logic                clk_sys,
   input wire logic                reset,
   input wire logic                ce,
   // inputs seen by the design
   input wire logic [NUM_CHAN-1:0] binary_input_channel,
   input wire logic                bus_comm_ok,
   input wire logic                module_error,
   input wire logic                config_error,
   input wire logic                img_rd_en,
   input wire logic [7:0]          img_rd_addr,
   // outputs
   input wire logic                img_rd_valid_ff,
   input wire logic [7:0]          img_rd_data_ff,
   input wire logic                img_rd_unmapped_ff,
   input wire logic [NUM_CHAN-1:0] input_process_image_ff,
   input wire logic [NUM_CHAN-1:0] chan_led_green_ff,
   input wire logic                bar_led_green_ff,
   input wire logic                bar_led_red_ff
);
   localparam logic [31:0] RUN_MAX = 32'(BLINK_HALF_CYC + 1);
   logic [2:0]  age_ff;
   logic [31:0] red_run_ff;
   logic [31:0] green_run_ff;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset || !ce);
   // age: sync chain flushed since reset or freeze
   always_ff @(posedge clk_sys) begin
      if (reset || !ce) age_ff <= 3'h0;
      else if (age_ff != 3'h7) age_ff <= age_ff + 3'h1;
   end
   // entry into blink may stretch the first run by two samples
   always_ff @(posedge clk_sys) begin
      if (reset || !ce || !config_error || $changed(bar_led_red_ff))
         red_run_ff <= 32'h0;
      else if (red_run_ff <= RUN_MAX) red_run_ff <= red_run_ff + 32'h1;
   end
   always_ff @(posedge clk_sys) begin
      if (reset || !ce || bus_comm_ok || $changed(bar_led_green_ff))
         green_run_ff <= 32'h0;
      else if (green_run_ff <= RUN_MAX) green_run_ff <= green_run_ff + 32'h1;
   end
   sequence s_settled;
      $stable(binary_input_channel)[*3] ##0 age_ff == 3'h7;
   endsequence
   sequence s_rd(logic [7:0] a);
      img_rd_en && img_rd_addr == a ##1 $stable(input_process_image_ff);
   endsequence
   chk_rd_answer: assert property (img_rd_en |=> img_rd_valid_ff)
      else $error("read not answered");
   chk_rd_byte0: assert property (s_rd(8'h00) |->
      img_rd_data_ff == input_process_image_ff[7:0]) else $error("byte0");
   chk_rd_byte1: assert property (s_rd(8'h01) |->
      img_rd_data_ff == input_process_image_ff[15:8]) else $error("byte1");
   chk_rd_unmapped: assert property (img_rd_en && img_rd_addr > 8'h01 |=>
      img_rd_unmapped_ff && img_rd_data_ff == 8'h00) else $error("unmapped");
   chk_image_sync: assert property (s_settled |->
      input_process_image_ff == binary_input_channel) else $error("image");
   chk_chan_led: assert property (s_settled |->
      chan_led_green_ff == binary_input_channel) else $error("channel led");
   chk_red_steady: assert property (module_error && !config_error |=>
      bar_led_red_ff) else $error("red not steady");
   chk_green_ok: assert property (bus_comm_ok && !module_error &&
      !config_error |=> bar_led_green_ff) else $error("green not steady");
   chk_red_blink: assert property (config_error |-> red_run_ff <= RUN_MAX)
      else $error("red not blinking");
   chk_green_blink: assert property (!bus_comm_ok |->
      green_run_ff <= RUN_MAX) else $error("green not blinking");
endmodule : sicm_chk
bind sicm_top sicm_chk #(.NUM_CHAN(NUM_CHAN),
   .BLINK_HALF_CYC(BLINK_HALF_CYC)) u_chk (.clk_sys(clk_sys),
   .reset(reset), .ce(ce), .binary_input_channel(binary_input_channel),
   .bus_comm_ok(bus_comm_ok), .module_error(module_error),
   .config_error(config_error), .img_rd_en(img_rd_en),
   .img_rd_addr(img_rd_addr), .img_rd_valid_ff(img_rd_valid_ff),
   .img_rd_data_ff(img_rd_data_ff), .img_rd_unmapped_ff(img_rd_unmapped_ff),
   .input_process_image_ff(input_process_image_ff),
   .chan_led_green_ff(chan_led_green_ff), .bar_led_red_ff(bar_led_red_ff),
   .bar_led_green_ff(bar_led_green_ff));

// file: verif/sicm_ctrl_model.sv
`timescale 1ns/10ps
module sicm_ctrl_model (
   // clock
   input wire logic       clk_sys,
   // read port
   output logic           img_rd_en,
   output logic [7:0]     img_rd_addr,
   input wire logic [7:0] img_rd_data_ff
);
   initial begin
      img_rd_en = 1'b0;
      img_rd_addr = 8'h5a;
   end
   // released address inverted so a stale value is never read back
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1 img_rd_en = 1'b1;
      img_rd_addr = a;
      @(posedge clk_sys);
      #1 img_rd_en = 1'b0;
      img_rd_addr = ~a;
      @(posedge clk_sys);
      d = img_rd_data_ff;
   endtask : rd
endmodule : sicm_ctrl_model

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   import sicm_pkg::*;
   localparam int HALF = 4;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] chan = 16'h0000;
   logic        bus_ok = 1'b1, mod_err = 1'b0, cfg_err = 1'b0;
   logic        ce = 1'b1;
   logic        rd_en, unmapped, led_g, led_r, pg, pr;
   logic [7:0]  rd_addr, rd_data, d;
   logic [15:0] image, leds;
   int          n_mismatch = 0, checked = 0, cycles = 0, seed = 41225;
   int          exp_img, n_r, n_g;
   int          exp_q[$];
   always #5 clk_sys = ~clk_sys;
   sicm_top #(.BLINK_HALF_CYC(HALF)) i_dut (.clk_sys(clk_sys), .reset(reset),
      .ce(ce), .binary_input_channel(chan), .bus_comm_ok(bus_ok),
      .module_error(mod_err), .config_error(cfg_err), .img_rd_en(rd_en),
      .img_rd_addr(rd_addr), .img_rd_valid_ff(), .img_rd_data_ff(rd_data),
      .img_rd_unmapped_ff(unmapped), .input_process_image_ff(image),
      .chan_led_green_ff(leds), .bar_led_green_ff(led_g),
      .bar_led_red_ff(led_r));
   sicm_ctrl_model u_ctrl (.clk_sys(clk_sys), .img_rd_en(rd_en),
      .img_rd_addr(rd_addr), .img_rd_data_ff(rd_data));
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      #1 reset = 1'b0;
      check("image at reset", image, SICM_IMG_RST);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         #1 chan = 16'($random(seed));
         exp_img = chan;
         exp_q.push_back(exp_img & 32'h0000_00ff);
         exp_q.push_back(exp_img >> 8);
         repeat (4) @(posedge clk_sys);
         #1 check("image", image, exp_img[15:0]);
         check("channel leds", leds, exp_img[15:0]);
         u_ctrl.rd(8'h00, d);
         check("byte0", d, 16'(exp_q.pop_front()));
         u_ctrl.rd(8'h01, d);
         check("byte1", d, 16'(exp_q.pop_front()));
         check("mapped flag", unmapped, 16'h0000);
      end
      for (int a = 2; a < 256; a += 253) begin
         u_ctrl.rd(8'(a), d);
         check("unmapped data", d, 16'h0000);
         check("unmapped flag", unmapped, 16'h0001);
      end
      @(posedge clk_sys);
      #1 ce = 1'b0;
      chan = ~chan;
      repeat (6) @(posedge clk_sys);
      #1 check("image frozen", image, exp_img[15:0]);
      check("leds frozen", leds, exp_img[15:0]);
      ce = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 check("image resumed", image, ~exp_img[15:0]);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         #1 mod_err = k[0];
         repeat (2) @(posedge clk_sys);
         #1 check("bar green", led_g, !k[0]);
         check("bar red", led_r, k[0]);
      end
      bus_ok = 1'b0;
      cfg_err = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 {n_r, n_g, pr, pg} = {32'd0, 32'd0, led_r, led_g};
      repeat (40) begin
         @(posedge clk_sys);
         #1 n_r += int'(led_r !== pr);
         n_g += int'(led_g !== pg);
         {pr, pg} = {led_r, led_g};
      end
      check("red toggles", n_r, 40 / HALF);
      check("green toggles", n_g, 40 / HALF);
      report_and_stop();
   end
endmodule : testbench
